/* File: logic/rtc_irq_pkg.sv */
// constants for the alarm, periodic interrupt and slow clock output block
// assumes an 8-bit register port and a 25 MHz system clock
package rtc_irq_pkg;
    // system clock
    localparam longint CLK_HZ          = 64'd25_000_000;
    // oscillator that feeds the sub-second divider
    localparam longint OSC_HZ          = 64'd32_768;
    // register port widths
    localparam int     ADDR_W          = 5;
    localparam int     DATA_W          = 8;
    // register offsets
    localparam logic [4:0] SEC_ADDR    = 5'h00; // second counter, write resets divider
    localparam logic [4:0] CTRL1_ADDR  = 5'h0E; // enables, clock enable b, selector
    localparam logic [4:0] CTRL2_ADDR  = 5'h0F; // flags, clock enable a
    localparam logic [4:0] IST_ADDR    = 5'h10; // sticky event status
    localparam logic [4:0] IMASK_ADDR  = 5'h11; // event mask
    // control register 1 fields
    localparam int WEN_BIT             = 7;
    localparam int DEN_BIT             = 6;
    localparam int CKEN_B_BIT          = 4;
    localparam int SEL_LSB             = 0;
    // control register 2 fields
    localparam int CKEN_A_BIT          = 3;
    localparam int PFLAG_BIT           = 2;
    localparam int WFLAG_BIT           = 1;
    localparam int DFLAG_BIT           = 0;
    // status and mask layout
    localparam int EV_DAILY            = 0;
    localparam int EV_WEEKDAY          = 1;
    localparam int EV_PERIODIC         = 2;
    // reset values
    localparam logic [7:0] CTRL_RST    = 8'h00;
    localparam logic [2:0] EV_RST      = 3'h0;
    // periodic selector codes
    localparam logic [2:0] SEL_OFF     = 3'h0;
    localparam logic [2:0] SEL_LOW     = 3'h1;
    localparam logic [2:0] SEL_P2HZ    = 3'h2;
    localparam logic [2:0] SEL_P1HZ    = 3'h3;
    localparam logic [2:0] SEL_L_SEC   = 3'h4;
    localparam logic [2:0] SEL_L_MIN   = 3'h5;
    localparam logic [2:0] SEL_L_HOUR  = 3'h6;
    localparam logic [2:0] SEL_L_MONTH = 3'h7;
    // divider: one second of oscillator ticks
    localparam logic [15:0] DIV_TOP    = 16'h7FFF;
    localparam logic [15:0] HALF_SEC   = 16'h4000;
    localparam logic [15:0] QUART_SEC  = 16'h2000;
    // pulse mode second increment lag
    localparam longint SEC_LAG_NS      = 64'd92_000;
    localparam logic [15:0] SEC_LAG_TICKS = 16'((SEC_LAG_NS * OSC_HZ) / 64'd1_000_000_000);
    // oscillation adjustment step
    localparam int     ADJ_SECONDS     = 20;
    localparam logic [4:0] ADJ_LAST    = 5'(ADJ_SECONDS - 1);
    localparam longint ADJ_MAX_NS      = 64'd3_784_000;
    localparam logic [7:0] ADJ_MAX_TICKS = 8'((ADJ_MAX_NS * OSC_HZ) / 64'd1_000_000_000);
    // bcd values for period boundaries
    localparam logic [6:0] BCD_ZERO    = 7'h00;
    localparam logic [5:0] BCD_DAY1    = 6'h01;
endpackage

/* File: logic/rtc_irq_clkout.sv */
// alarm comparators, periodic interrupt and gated slow clock output
// assumes time counters outside on clk that step on sec_tick and show new
// values in the next cycle; oscillator arrives as an unsynchronised pin
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns

// Functional notes
// - alarm enable bit 1 arms, 0 disarms
// - flag reads match; write 0 clears, 1 ignored
// - clearing flag keeps enable; next match fires
// - weekday alarm: day,hour,minute; daily: hour,minute
// - selector 000 output off, 001 fixed low
// - 010 2Hz, 011 1Hz, half duty, second-synced
// - level codes: second, minute, hour, month start
// - level mode holds low until flag written 0
// - level falling edge at second increment
// - adjustment shifts period once per 20 seconds
// - pulse mode second increments 92us after fall
// - second write resets divider, pulse output low
// - gated: clock runs if either enable low
// - ungated variant: clock always runs
// - clock gating changes only at clean edges
// - interrupt pin low while any source active
// - bit positions in control registers Eh, Fh
module rtc_irq_clkout
    import rtc_irq_pkg::*;
#(
    parameter bit GATED = 1'b1                              // 0 selects ungated variant
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [rtc_irq_pkg::ADDR_W-1:0] addr,
    input  wire logic [rtc_irq_pkg::DATA_W-1:0] wdata,
    input  wire logic                        wr,
    input  wire logic                        rd,
    output logic      [rtc_irq_pkg::DATA_W-1:0] rdata,
    input  wire logic                        osc_in,
    input  wire logic [6:0]                  cur_second,
    input  wire logic [6:0]                  cur_minute,
    input  wire logic [5:0]                  cur_hour,
    input  wire logic [2:0]                  cur_weekday,
    input  wire logic [5:0]                  cur_day,
    input  wire logic [6:0]                  alarm_w_minute,
    input  wire logic [5:0]                  alarm_w_hour,
    input  wire logic [6:0]                  alarm_w_days,
    input  wire logic [6:0]                  alarm_d_minute,
    input  wire logic [5:0]                  alarm_d_hour,
    input  wire logic                        adjust_active,
    input  wire logic signed [7:0]           adjust_ticks,
    output logic                             sec_tick,
    input  wire logic                        irq_out_n_in,
    output logic                             irq_out_n_out,
    output logic                             irq_out_n_oe_n,
    input  wire logic                        slow_clock_out_in,
    output logic                             slow_clock_out_out,
    output logic                             slow_clock_out_oe_n,
    output logic                             irq
);
    import rtc_irq_pkg::*;

    // whole block state
    typedef struct packed {
        logic        osc_s1;      // first sync stage, feeds osc_s2 only
        logic        osc_s2;
        logic        osc_s3;
        logic        osc_lvl;     // accepted oscillator level
        logic [15:0] div;         // sub-second divider
        logic [4:0]  sec20;       // seconds since last adjustment
        logic        lvl_chk;     // evaluate level event next cycle
        logic        wen;
        logic        den;
        logic        cken_a_n;
        logic        cken_b_n;
        logic [2:0]  sel;
        logic        wflag;
        logic        dflag;
        logic        pflag;
        logic        wmatch;      // last weekday match, for edge detect
        logic        dmatch;      // last daily match
        logic [2:0]  ist;         // sticky event status
        logic [2:0]  imask;       // event mask
        logic        gate;        // clock output gate
        logic [7:0]  rdata;
        logic        sec_tick;
        logic        pin_oe_n;
        logic        clk_oe_n;
        logic        irq;
    } state_t;

    state_t s_reg;   // registered state
    state_t s_next;  // next state

    // helper terms
    logic        osc_rise;   // accepted rising edge of oscillator
    logic        pulse_mode;
    logic        level_mode;
    logic [15:0] top;        // divider end value this second
    logic        sec_end;    // divider wraps on this tick
    logic        lag_hit;    // pulse mode delayed increment point
    logic        sec_wr;
    logic        c1_wr;
    logic        c2_wr;
    logic        wmatch_now;
    logic        dmatch_now;
    logic        w_event;
    logic        d_event;
    logic        p_event;
    logic        pulse_low;
    logic        pin_low;
    logic [7:0]  adj_mag;    // clamped adjustment magnitude
    logic [2:0]  ev;

    // edge and mode decode
    always_comb begin
        osc_rise   = (s_reg.osc_s2 == s_reg.osc_s3) && s_reg.osc_s3 && !s_reg.osc_lvl;
        pulse_mode = (s_reg.sel == SEL_P2HZ) || (s_reg.sel == SEL_P1HZ);
        level_mode = s_reg.sel[2];
        sec_wr     = wr && (addr == SEC_ADDR);
        c1_wr      = wr && (addr == CTRL1_ADDR);
        c2_wr      = wr && (addr == CTRL2_ADDR);
    end

    // once every 20 seconds the second is stretched or shortened
    always_comb begin
        adj_mag = adjust_ticks[7] ? 8'(-adjust_ticks) : 8'(adjust_ticks);
        if (adj_mag > ADJ_MAX_TICKS) begin
            adj_mag = ADJ_MAX_TICKS;  // limit of the shift
        end
        top = DIV_TOP;
        if (adjust_active && (s_reg.sec20 == ADJ_LAST)) begin
            // positive value shortens the second, negative lengthens
            if (adjust_ticks[7]) begin
                top = DIV_TOP + {8'h00, adj_mag};
            end else begin
                top = DIV_TOP - {8'h00, adj_mag};
            end
        end
        sec_end = osc_rise && (s_reg.div == top);
        lag_hit = osc_rise && (s_reg.div == (SEC_LAG_TICKS - 16'h0001));
    end

    // alarm comparators; edge of enabled match so a cleared flag stays clear
    // for the rest of the matching minute
    always_comb begin
        wmatch_now = s_reg.wen && alarm_w_days[cur_weekday]
                     && (cur_hour == alarm_w_hour) && (cur_minute == alarm_w_minute);
        dmatch_now = s_reg.den && (cur_hour == alarm_d_hour)
                     && (cur_minute == alarm_d_minute);
        w_event    = wmatch_now && !s_reg.wmatch;
        d_event    = dmatch_now && !s_reg.dmatch;
    end

    // level mode event, judged on the counters in the sec_tick cycle, just before they step
    always_comb begin
        p_event = 1'b0;
        if (s_reg.lvl_chk) begin
            case (s_reg.sel)
                SEL_L_SEC: begin
                    p_event = 1'b1;
                end
                SEL_L_MIN: begin
                    p_event = (cur_second == BCD_ZERO);
                end
                SEL_L_HOUR: begin
                    p_event = (cur_second == BCD_ZERO) && (cur_minute == BCD_ZERO);
                end
                SEL_L_MONTH: begin
                    p_event = (cur_second == BCD_ZERO) && (cur_minute == BCD_ZERO)
                              && (cur_hour == BCD_ZERO[5:0]) && (cur_day == BCD_DAY1);
                end
                default: begin
                    p_event = 1'b0;
                end
            endcase
        end
    end

    // pulse waveform: low in the first half of each period
    always_comb begin
        if (s_reg.sel == SEL_P1HZ) begin
            pulse_low = s_reg.div < HALF_SEC;
        end else begin
            pulse_low = (s_reg.div < QUART_SEC) ||
                        ((s_reg.div >= HALF_SEC) && (s_reg.div < (HALF_SEC + QUART_SEC)));
        end
    end

    // interrupt pin combines every source
    always_comb begin
        pin_low = s_reg.wflag || s_reg.dflag;
        case (s_reg.sel)
            SEL_OFF: begin
                pin_low = pin_low;
            end
            SEL_LOW: begin
                pin_low = 1'b1;
            end
            SEL_P2HZ, SEL_P1HZ: begin
                pin_low = pin_low || pulse_low;
            end
            default: begin
                pin_low = pin_low || s_reg.pflag;
            end
        endcase
    end

    // next state
    always_comb begin
        s_next = s_reg;

        // oscillator sync; a change counts once stages two and three agree
        s_next.osc_s1 = osc_in;
        s_next.osc_s2 = s_reg.osc_s1;
        s_next.osc_s3 = s_reg.osc_s2;
        if (s_reg.osc_s2 == s_reg.osc_s3) begin
            s_next.osc_lvl = s_reg.osc_s3;
        end

        // divider and second increment
        s_next.sec_tick = 1'b0;
        s_next.lvl_chk  = 1'b0;
        if (sec_wr) begin
            // restart sub-second stages; pulse output falls with div at zero
            s_next.div   = 16'h0000;
        end else if (sec_end) begin
            s_next.div   = 16'h0000;
            s_next.sec20 = (s_reg.sec20 == ADJ_LAST) ? 5'h00 : s_reg.sec20 + 5'h01;
            if (!pulse_mode) begin
                s_next.sec_tick = 1'b1;
                s_next.lvl_chk  = level_mode;
            end
        end else if (osc_rise) begin
            s_next.div = s_reg.div + 16'h0001;
        end
        if (pulse_mode && lag_hit && !sec_wr) begin
            s_next.sec_tick = 1'b1;
        end

        // match history
        s_next.wmatch = wmatch_now;
        s_next.dmatch = dmatch_now;

        // control register 1
        if (c1_wr) begin
            s_next.wen      = wdata[WEN_BIT];
            s_next.den      = wdata[DEN_BIT];
            s_next.cken_b_n = wdata[CKEN_B_BIT];
            s_next.sel      = wdata[SEL_LSB +: 3];
        end

        // control register 2 flags: zero clears, one leaves alone
        if (c2_wr) begin
            s_next.cken_a_n = wdata[CKEN_A_BIT];
            s_next.pflag    = s_reg.pflag && wdata[PFLAG_BIT];
            s_next.wflag    = s_reg.wflag && wdata[WFLAG_BIT];
            s_next.dflag    = s_reg.dflag && wdata[DFLAG_BIT];
        end
        // a hardware set in the same cycle wins over the clear
        if (w_event) begin
            s_next.wflag = 1'b1;
        end
        if (d_event) begin
            s_next.dflag = 1'b1;
        end
        if (p_event) begin
            s_next.pflag = 1'b1;
        end

        // sticky status, write one to clear, set wins
        ev = 3'h0;
        ev[EV_DAILY]    = d_event;
        ev[EV_WEEKDAY]  = w_event;
        ev[EV_PERIODIC] = p_event;
        if (wr && (addr == IST_ADDR)) begin
            s_next.ist = s_reg.ist & ~wdata[2:0];
        end
        s_next.ist = s_next.ist | ev;
        if (wr && (addr == IMASK_ADDR)) begin
            s_next.imask = wdata[2:0];
        end
        s_next.irq = |(s_next.ist & s_next.imask);

        // read data only in the cycle after the strobe
        s_next.rdata = 8'h00;
        if (rd) begin
            case (addr)
                CTRL1_ADDR: begin
                    s_next.rdata = {s_reg.wen, s_reg.den, 1'b0, s_reg.cken_b_n, 1'b0, s_reg.sel};
                end
                CTRL2_ADDR: begin
                    s_next.rdata = {4'h0, s_reg.cken_a_n, s_reg.pflag, s_reg.wflag, s_reg.dflag};
                end
                IST_ADDR: begin
                    s_next.rdata = {5'h00, s_reg.ist};
                end
                IMASK_ADDR: begin
                    s_next.rdata = {5'h00, s_reg.imask};
                end
                default: begin
                    s_next.rdata = 8'h00; // unmapped reads as zero
                end
            endcase
        end

        // clock gate moves only on a rising oscillator edge, when the pin is
        // already high, so a pulse is never cut short
        if (osc_rise) begin
            s_next.gate = GATED ? (!s_reg.cken_a_n || !s_reg.cken_b_n) : 1'b1;
        end
        s_next.clk_oe_n = !(s_next.gate && !s_next.osc_lvl);
        s_next.pin_oe_n = !pin_low;
    end

    // single state register
    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
            s_reg.clk_oe_n <= 1'b1;
            s_reg.pin_oe_n <= 1'b1;
            s_reg.gate     <= GATED ? 1'b1 : 1'b1; // both enables default low
            s_reg.wen      <= CTRL_RST[WEN_BIT];
            s_reg.ist      <= EV_RST;
            s_reg.imask    <= EV_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ports straight from the register; open-drain pins only drive low
    assign rdata               = s_reg.rdata;
    assign sec_tick            = s_reg.sec_tick;
    assign irq_out_n_out       = 1'b0;
    assign irq_out_n_oe_n      = s_reg.pin_oe_n;
    assign slow_clock_out_out  = 1'b0;
    assign slow_clock_out_oe_n = s_reg.clk_oe_n;
    assign irq                 = s_reg.irq;
endmodule

/* File: test/rtc_irq_clkout_props.sv */
// checker for the alarm, periodic interrupt and slow clock block
// sees only the top module ports; bound to every instance at the foot
`timescale 1ns/1ns
module rtc_irq_clkout_chk
    import rtc_irq_pkg::*;
#(
    parameter bit GATED = 1'b1 // 0 means the clock never stops
) (
    input wire logic                             clk,
    input wire logic                             rst,
    input wire logic [rtc_irq_pkg::ADDR_W-1:0]   addr,
    input wire logic [rtc_irq_pkg::DATA_W-1:0]   wdata,
    input wire logic                             wr,
    input wire logic                             rd,
    input wire logic [rtc_irq_pkg::DATA_W-1:0]   rdata,
    input wire logic                             sec_tick,
    input wire logic                             irq_out_n_oe_n,
    input wire logic                             slow_clock_out_oe_n,
    input wire logic                             irq
);
    // shadow of the host-written control bits plus two run counters
    typedef struct packed {
        logic [2:0] sel;    // periodic selector as last written
        logic       cka_n;  // clock enable a, active low
        logic       ckb_n;  // clock enable b, active low
        logic       ctl_wr; // control write one cycle ago
        logic       run;    // clock output should be running
        logic [6:0] phase;  // cycles since run last changed
        logic       oe_q;   // previous clock pin enable
        logic [6:0] flat;   // cycles the clock pin has not moved
    } chk_state_t;
    chk_state_t st_reg;
    chk_state_t st_next;
    logic       run_now;
    // gate is judged from shadow bits; ungated variant always runs
    assign run_now = !GATED || !(st_reg.cka_n && st_reg.ckb_n);
    // next shadow; counters saturate so long runs never wrap
    always_comb begin
        st_next = st_reg;
        st_next.ctl_wr = wr && (addr == CTRL1_ADDR || addr == CTRL2_ADDR);
        if (wr && addr == CTRL1_ADDR) begin
            st_next.sel = wdata[2:0];
            st_next.ckb_n = wdata[CKEN_B_BIT];
        end
        if (wr && addr == CTRL2_ADDR) begin
            st_next.cka_n = wdata[CKEN_A_BIT];
        end
        st_next.run = run_now;
        st_next.phase = (run_now != st_reg.run) ? 7'h00 : st_reg.phase + {6'h00, st_reg.phase != 7'h7F};
        st_next.oe_q = slow_clock_out_oe_n;
        st_next.flat = (slow_clock_out_oe_n != st_reg.oe_q) ? 7'h00 : st_reg.flat + {6'h00, st_reg.flat != 7'h7F};
        if (rst) begin
            st_next = '0;
            st_next.run = 1'b1;
        end
    end
    // one register for the whole shadow
    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_reset_quiet: assert property ($past(rst) |-> irq_out_n_oe_n && !irq && !sec_tick)
        else $error("interrupt pin or tick active right after reset");
    a_ctrl2_layout: assert property (rd && addr == CTRL2_ADDR |=> rdata[7:4] == 4'h0)
        else $error("reserved flag register bits read nonzero");
    a_flag_clear: assert property (wr && addr == CTRL2_ADDR && wdata[1:0] == 2'b00 ##1 rd && addr == CTRL2_ADDR
        |=> rdata[1:0] == 2'b00)
        else $error("alarm flag survived a zero write");
    a_fixed_low: assert property (wr && addr == CTRL1_ADDR && wdata[2:0] == SEL_LOW |-> ##[1:3] !irq_out_n_oe_n)
        else $error("fixed low selector did not pull the pin");
    a_second_restart: assert property (wr && addr == SEC_ADDR && st_reg.sel[2:1] == 2'b01
        |-> ##[1:3] !irq_out_n_oe_n)
        else $error("second write in pulse mode did not pull the pin");
    a_level_hold: assert property (st_reg.sel[2] && !irq_out_n_oe_n && !st_reg.ctl_wr
        && !(wr && (addr == CTRL1_ADDR || addr == CTRL2_ADDR)) |=> !irq_out_n_oe_n)
        else $error("level interrupt released without a flag write");
    a_clk_stop: assert property (!st_reg.run && st_reg.phase >= 7'd40 |-> slow_clock_out_oe_n)
        else $error("clock pin moved while both enables are off");
    a_clk_runs: assert property (st_reg.run && st_reg.phase >= 7'd40 |-> st_reg.flat < 7'd40)
        else $error("clock pin stuck while enabled");
    a_no_runt: assert property ($fell(slow_clock_out_oe_n) |=> !slow_clock_out_oe_n)
        else $error("one cycle clock pulse seen");
    c_alarm_low: cover property (st_reg.sel == SEL_OFF && !irq_out_n_oe_n);
    c_pulse_low: cover property (wr && addr == SEC_ADDR && st_reg.sel == SEL_P2HZ);
    c_clk_off: cover property (!st_reg.run && st_reg.phase == 7'h7F);
endmodule
bind rtc_irq_clkout rtc_irq_clkout_chk #(.GATED(GATED)) u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .sec_tick(sec_tick), .irq_out_n_oe_n(irq_out_n_oe_n),
    .slow_clock_out_oe_n(slow_clock_out_oe_n), .irq(irq));

/* File: test/host_pin_model.sv */
// host side of the two open-drain pins: pull-ups and a pulse counter
// assumes enables from the block, low meaning the pin is sunk
`timescale 1ns/1ns
module host_pin_model (
    input  wire logic        irq_oe_n,
    input  wire logic        ck_oe_n,
    output logic             irq_pin,
    output logic             ck_pin,
    output logic [15:0]      ck_falls
);
    // pull-up wins whenever nobody sinks the line
    assign irq_pin = irq_oe_n ? 1'b1 : 1'b0;
    assign ck_pin  = ck_oe_n ? 1'b1 : 1'b0;
    // host counts every clock pulse it receives
    initial ck_falls = 16'h0000;
    always @(negedge ck_pin) begin
        ck_falls <= ck_falls + 16'h0001;
    end
endmodule

/* File: test/rtc_irq_clkout_test.sv */
// self-checking bench for the alarm, periodic and slow clock block
// assumes the host pin model beside it; time counters are bench inputs
`timescale 1ns/1ns
module rtc_irq_clkout_test;
    import rtc_irq_pkg::*;
    localparam int LIMIT = 60000; // pulse wait is about 49k cycles
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [4:0]  addr = 5'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  rdata;
    logic        osc_in = 1'b0;
    logic [6:0]  cur_minute = 7'h30;
    logic [5:0]  cur_hour = 6'h12;
    logic [2:0]  cur_weekday = 3'h2;
    logic [6:0]  alarm_w_days = 7'h01;  // weekday 0 only: no match yet
    logic [6:0]  alarm_d_minute = 7'h29; // daily alarm starts a minute off
    logic [5:0]  alarm_d_hour = 6'h13;   // and an hour off, so each field is proven
    logic [5:0]  alarm_w_hour = 6'h12;
    logic        sec_tick, irq, irq_pin, ck_pin, irq_oe_n, ck_oe_n, irq_o, ck_o;
    logic [15:0] ck_falls;
    int          err_count = 0;
    int          cmp_count = 0;
    int          cyc = 0;
    // 25 MHz system clock; oscillator at 6 clocks, offset off the edges
    always #20 clk = ~clk;
    initial begin
        #3;
        forever #120 osc_in = ~osc_in;
    end
    rtc_irq_clkout dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .osc_in(osc_in), .cur_second(7'h00), .cur_minute(cur_minute), .cur_hour(cur_hour),
        .cur_weekday(cur_weekday), .cur_day(6'h01), .alarm_w_minute(7'h30), .alarm_w_hour(alarm_w_hour),
        .alarm_w_days(alarm_w_days), .alarm_d_minute(alarm_d_minute), .alarm_d_hour(alarm_d_hour),
        .adjust_active(1'b0),
        .adjust_ticks(8'sh00), .sec_tick(sec_tick), .irq_out_n_in(irq_pin), .irq_out_n_out(irq_o),
        .irq_out_n_oe_n(irq_oe_n), .slow_clock_out_in(ck_pin), .slow_clock_out_out(ck_o),
        .slow_clock_out_oe_n(ck_oe_n), .irq(irq));
    host_pin_model host (.irq_oe_n(irq_oe_n), .ck_oe_n(ck_oe_n), .irq_pin(irq_pin), .ck_pin(ck_pin),
        .ck_falls(ck_falls));
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ends between edges so outputs have settled
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask
    // write then read with no gap, as the bus allows back to back strobes
    task automatic wr_rd_chk(input logic [4:0] a, input logic [7:0] d, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        check(rdata, exp);
    endtask
    task automatic t_reset_values();
        rd_chk(CTRL1_ADDR, CTRL_RST);
        rd_chk(CTRL2_ADDR, 8'h00);
        rd_chk(IST_ADDR, 8'h00);
        rd_chk(IMASK_ADDR, 8'h00);
        rd_chk(5'h05, 8'h00);
        check({7'h00, irq_pin}, 8'h01);
    endtask
    task automatic t_alarms();
        wr_reg(CTRL1_ADDR, 8'h00);
        @(posedge clk);
        cur_minute <= 7'h31;
        wait_cyc(3);
        @(posedge clk);
        cur_minute <= 7'h30;
        wait_cyc(3);
        rd_chk(CTRL2_ADDR, 8'h00);
        wr_reg(CTRL1_ADDR, 8'hC0);
        wait_cyc(3);
        rd_chk(CTRL2_ADDR, 8'h00);
        @(posedge clk);
        alarm_d_hour <= 6'h12;
        wait_cyc(3);
        rd_chk(CTRL2_ADDR, 8'h00);
        @(posedge clk);
        alarm_d_minute <= 7'h30;
        wait_cyc(3);
        rd_chk(CTRL2_ADDR, 8'h01);
        check({7'h00, irq_pin}, 8'h00);
        check({7'h00, irq}, 8'h00);
        wr_reg(IMASK_ADDR, 8'h07);
        wait_cyc(2);
        check({7'h00, irq}, 8'h01);
        rd_chk(IST_ADDR, 8'h01);
        wr_reg(IST_ADDR, 8'h01);
        wait_cyc(2);
        check({7'h00, irq}, 8'h00);
        wr_rd_chk(CTRL2_ADDR, 8'h07, 8'h01);
        wr_rd_chk(CTRL2_ADDR, 8'h00, 8'h00);
        wait_cyc(2);
        check({7'h00, irq_pin}, 8'h01);
        rd_chk(CTRL1_ADDR, 8'hC0);
        @(posedge clk);
        alarm_w_days <= 7'h04;
        alarm_w_hour <= 6'h13;
        wait_cyc(3);
        rd_chk(CTRL2_ADDR, 8'h00);
        @(posedge clk);
        alarm_w_hour <= 6'h12;
        wait_cyc(3);
        rd_chk(CTRL2_ADDR, 8'h02);
        @(posedge clk);
        cur_minute <= 7'h31;
        wait_cyc(2);
        @(posedge clk);
        cur_minute <= 7'h30;
        wait_cyc(3);
        rd_chk(CTRL2_ADDR, 8'h03);
        wr_reg(CTRL1_ADDR, 8'hC4);
        wait_cyc(4);
        check({7'h00, irq_pin}, 8'h00);
        wr_reg(CTRL1_ADDR, 8'h00);
        wr_reg(CTRL2_ADDR, 8'h00);
        wr_reg(IST_ADDR, 8'h07);
        wait_cyc(3);
        check({7'h00, irq_pin}, 8'h01);
        check({7'h00, irq}, 8'h00);
    endtask
    task automatic t_periodic();
        int n;
        wr_reg(CTRL1_ADDR, {5'h00, SEL_LOW});
        wait_cyc(3);
        check({7'h00, irq_pin}, 8'h00);
        rd_chk(CTRL2_ADDR, 8'h00);
        wr_reg(CTRL1_ADDR, {5'h00, SEL_OFF});
        wait_cyc(3);
        check({7'h00, irq_pin}, 8'h01);
        wr_reg(CTRL1_ADDR, {5'h00, SEL_P2HZ});
        wr_reg(SEC_ADDR, 8'h00);
        wait_cyc(3);
        check({7'h00, irq_pin}, 8'h00);
        n = 0;
        while (irq_pin === 1'b0 && n < 9000) begin
            @(posedge osc_in);
            n++;
        end
        check({7'h00, n >= 8185 && n <= 8200}, 8'h01);
        wr_reg(CTRL1_ADDR, {5'h00, SEL_OFF});
    endtask
    task automatic t_clkout();
        logic [15:0] f0;
        wr_reg(CTRL1_ADDR, 8'h10);
        wait_cyc(20);
        f0 = ck_falls;
        wait_cyc(60);
        check({7'h00, ck_falls != f0}, 8'h01);
        wr_reg(CTRL2_ADDR, 8'h0F);
        wait_cyc(20);
        f0 = ck_falls;
        wait_cyc(60);
        check({7'h00, ck_falls == f0 && ck_pin === 1'b1}, 8'h01);
        wr_reg(CTRL2_ADDR, 8'h07);
        wait_cyc(20);
        f0 = ck_falls;
        wait_cyc(60);
        check({7'h00, ck_falls != f0}, 8'h01);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset_values();
        t_alarms();
        t_periodic();
        t_clkout();
        tally_and_finish();
    end
endmodule
